// >>> rtl/rheo_pkg.sv
// rheo_pkg: constants, command codes and carriers of the wiper control
// assumes one clock domain and a 32-bit apb register bus
package rheo_pkg;
   // command codes arriving from the serial front end
   localparam logic [3:0] CMD_NOP = 4'h0;
   localparam logic [3:0] CMD_WIPER_WR = 4'h1;
   localparam logic [3:0] CMD_WIPER_RD = 4'h2;
   localparam logic [3:0] CMD_PROGRAM = 4'h3;
   localparam logic [3:0] CMD_SW_RESET = 4'h4;
   localparam logic [3:0] CMD_MEM_RD = 4'h5;
   localparam logic [3:0] CMD_LAST_RD = 4'h6;
   localparam logic [3:0] CMD_CTRL_WR = 4'h7;
   localparam logic [3:0] CMD_CTRL_RD = 4'h8;
   localparam logic [3:0] CMD_SHUTDOWN = 4'h9;
   // apb register byte offsets
   localparam logic [7:0] CTRL_OFS = 8'h00;
   localparam logic [7:0] STATE_OFS = 8'h04;
   localparam logic [7:0] INT_STS_OFS = 8'h08;
   localparam logic [7:0] INT_MASK_OFS = 8'h0C;
   // control field positions
   localparam int CTRL_MPE_BIT = 0;
   localparam int CTRL_WWE_BIT = 1;
   localparam int CTRL_TOL_BIT = 2;
   localparam int CTRL_OK_BIT = 3;
   localparam logic [2:0] CTRL_RESET = 3'h4;
   // state register field positions
   localparam int ST_LAST_LSB = 16;
   localparam int ST_BUSY_BIT = 24;
   localparam int ST_SHDN_BIT = 25;
   // interrupt event positions
   localparam int EV_PROG_DONE = 0;
   localparam int EV_RELOAD = 1;
   localparam int EV_SHDN = 2;
   localparam int EV_DROP = 3;
   localparam int EV_BITS = 4;
   // memory geometry
   localparam int MEM_LOCS = 50;
   localparam int LOC_BITS = 6;
   localparam logic [5:0] LOC_FIRST = 6'h01;
   localparam int MEM_SEL_BITS = 6;
   // internal write cycle time
   localparam int OTP_WRITE_MS = 350;
   localparam int CLK_KHZ = 125000;
   localparam int OTP_WRITE_CYC = OTP_WRITE_MS * CLK_KHZ;
   localparam int BUSY_CNT_BITS = 26;
   // preset sequencer
   typedef enum logic [1:0] {
      SEQ_MID = 2'b00,
      SEQ_RESTORE = 2'b01,
      SEQ_IDLE = 2'b10,
      SEQ_BUSY = 2'b11
   } seq_e;
   // one decoded command
   typedef struct packed {
      logic [3:0] code;
      logic [9:0] data;
   } cmd_s;
endpackage

// >>> rtl/rheostat_wiper_control.sv
// rheostat_wiper_control: wiper register, tap decode, preset, reset,
// shutdown, one-time-programmable wiper memory and apb status view
// assumes decoded commands from a serial front end on pclk and a
// reset pin already synchronous to pclk
//
// Operation
// RULE1: each memory program starts an internal write cycle; interface disabled.
// RULE2: own address not acknowledged while the write cycle runs.
// RULE3: controller polls with start, address, write bit until acknowledged.
// RULE4: command 4 or low reset pin reloads wiper from last programmed location.
// RULE5: with nothing programmed, reset loads midscale.
// RULE6: tolerance calibration control bit, enabled by default.
// RULE7: command 9 with data bit 0 set enters shutdown, wiper off terminal A.
// RULE8: command 9 with bit 0 clear, or any reset, leaves shutdown.
// RULE9: all commands still execute during shutdown.
// RULE10: wiper value decodes to exactly one tap of 1024 or 256.
// RULE11: power-up sets midscale, then restores last programmed value; presetn also clears the memory, so the restore step loads midscale.
// RULE12: wiper write enable resets to 0; resets still refresh wiper.
// RULE13: memory program enable resets to 0 and gates programming.
// RULE14: program stores wiper at next location from 0x01 until full.
// RULE15: readable success flag set when a program completes.
// RULE16: write cycle length is a clock-count parameter.
`timescale 1ns/100ps
module rheostat_wiper_control #(
   parameter int WIPER_BITS = 10,
   parameter int WRITE_CYCLES = rheo_pkg::OTP_WRITE_CYC
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [7:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [3:0] pstrb,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // command port from the serial front end
   input wire logic cmd_valid,
   input wire rheo_pkg::cmd_s cmd,
   output logic addr_ack_en,
   output logic [15:0] read_word,
   // reset pin, synchronous to pclk
   input wire logic reset_pin_n,
   // analog side
   output logic [(1<<WIPER_BITS)-1:0] tap_sel,
   output logic wiper_a_connect,
   output logic tolerance_cal_en,
   // interrupt
   output logic irq
);
   localparam int TAPS = 1 << WIPER_BITS;
   localparam logic [WIPER_BITS-1:0] MIDSCALE =
      WIPER_BITS'(TAPS / 2);

   rheo_pkg::seq_e seq_ff, nxt_seq;
   logic [WIPER_BITS-1:0] wiper_register_ff, nxt_wiper_register;
   logic [WIPER_BITS-1:0] otp_wiper_memory_ff [rheo_pkg::MEM_LOCS];
   logic [WIPER_BITS-1:0] nxt_otp_wiper_memory [rheo_pkg::MEM_LOCS];
   logic [rheo_pkg::LOC_BITS-1:0] last_loc_ff, nxt_last_loc;
   logic [rheo_pkg::BUSY_CNT_BITS-1:0] busy_cnt_ff, nxt_busy_cnt;
   logic memory_program_enable_bit_ff, nxt_memory_program_enable_bit;
   logic wiper_write_enable_bit_ff, nxt_wiper_write_enable_bit;
   logic tolerance_cal_bit_ff, nxt_tolerance_cal_bit;
   logic program_success_flag_ff, nxt_program_success_flag;
   logic shutdown_ff, nxt_shutdown;
   logic [15:0] read_word_ff, nxt_read_word;
   logic [rheo_pkg::EV_BITS-1:0] int_sts_ff, nxt_int_sts;
   logic [rheo_pkg::EV_BITS-1:0] int_mask_ff, nxt_int_mask;
   logic [31:0] prdata_ff, nxt_prdata;
   logic [rheo_pkg::EV_BITS-1:0] ev;
   logic [WIPER_BITS-1:0] restore_val;
   logic take_cmd, apb_wr, apb_rd, apb_hit;
   logic [rheo_pkg::MEM_SEL_BITS-1:0] rd_sel;

   // value a reset reloads: last programmed location or midscale
   always_comb begin
      restore_val = MIDSCALE; // RULE5
      if (last_loc_ff != '0) begin
         restore_val = otp_wiper_memory_ff[last_loc_ff - 6'h01]; // RULE4
      end
   end

   // commands are only taken while no write cycle runs
   assign take_cmd = cmd_valid && (seq_ff == rheo_pkg::SEQ_IDLE); // RULE1
   assign addr_ack_en = (seq_ff != rheo_pkg::SEQ_BUSY); // RULE2
   assign rd_sel = cmd.data[rheo_pkg::MEM_SEL_BITS-1:0];

   // apb access decode; every access completes in its first access cycle
   assign apb_wr = psel && penable && pwrite;
   assign apb_rd = psel && !penable && !pwrite;
   always_comb begin
      unique case (paddr)
         rheo_pkg::CTRL_OFS, rheo_pkg::STATE_OFS,
         rheo_pkg::INT_STS_OFS, rheo_pkg::INT_MASK_OFS: apb_hit = 1'b1;
         default: apb_hit = 1'b0;
      endcase
   end
   assign pready = 1'b1;
   assign pslverr = psel && penable && !apb_hit;
   assign prdata = prdata_ff;

   // command interpreter, preset sequencer and write cycle timer
   always_comb begin
      nxt_seq = seq_ff;
      nxt_wiper_register = wiper_register_ff;
      nxt_otp_wiper_memory = otp_wiper_memory_ff;
      nxt_last_loc = last_loc_ff;
      nxt_busy_cnt = busy_cnt_ff;
      nxt_memory_program_enable_bit = memory_program_enable_bit_ff;
      nxt_wiper_write_enable_bit = wiper_write_enable_bit_ff;
      nxt_tolerance_cal_bit = tolerance_cal_bit_ff;
      nxt_program_success_flag = program_success_flag_ff;
      nxt_shutdown = shutdown_ff;
      nxt_read_word = read_word_ff;
      ev = '0;
      unique case (seq_ff)
         rheo_pkg::SEQ_MID: begin
            nxt_wiper_register = MIDSCALE; // RULE11
            nxt_seq = rheo_pkg::SEQ_RESTORE;
         end
         rheo_pkg::SEQ_RESTORE: begin
            nxt_wiper_register = restore_val; // RULE11
            nxt_seq = rheo_pkg::SEQ_IDLE;
         end
         rheo_pkg::SEQ_BUSY: begin
            // interface stays locked until the count runs out
            if (busy_cnt_ff == '0) begin
               nxt_program_success_flag = 1'b1; // RULE15
               ev[rheo_pkg::EV_PROG_DONE] = 1'b1;
               nxt_seq = rheo_pkg::SEQ_IDLE; // RULE2
            end else begin
               nxt_busy_cnt = busy_cnt_ff - 1'b1;
            end
            if (cmd_valid) begin
               ev[rheo_pkg::EV_DROP] = 1'b1; // RULE1
            end
         end
         rheo_pkg::SEQ_IDLE: begin
            // shutdown does not gate any command
            if (take_cmd) begin // RULE9
               unique case (cmd.code)
                  rheo_pkg::CMD_WIPER_WR: begin
                     if (wiper_write_enable_bit_ff) begin // RULE12
                        nxt_wiper_register = cmd.data[WIPER_BITS-1:0];
                     end else begin
                        ev[rheo_pkg::EV_DROP] = 1'b1;
                     end
                  end
                  rheo_pkg::CMD_WIPER_RD: begin
                     nxt_read_word = 16'(wiper_register_ff);
                  end
                  rheo_pkg::CMD_PROGRAM: begin
                     if (memory_program_enable_bit_ff && // RULE13
                         last_loc_ff < 6'(rheo_pkg::MEM_LOCS)) begin
                        // next free slot; first one is location 0x01
                        nxt_otp_wiper_memory[last_loc_ff] =
                           wiper_register_ff; // RULE14
                        nxt_last_loc = last_loc_ff + rheo_pkg::LOC_FIRST;
                        nxt_program_success_flag = 1'b0;
                        nxt_busy_cnt = rheo_pkg::BUSY_CNT_BITS'(
                           WRITE_CYCLES - 1); // RULE16
                        nxt_seq = rheo_pkg::SEQ_BUSY; // RULE1
                     end else begin
                        ev[rheo_pkg::EV_DROP] = 1'b1;
                     end
                  end
                  rheo_pkg::CMD_SW_RESET: begin
                     nxt_wiper_register = restore_val; // RULE4
                     nxt_shutdown = 1'b0; // RULE8
                     ev[rheo_pkg::EV_RELOAD] = 1'b1;
                  end
                  rheo_pkg::CMD_MEM_RD: begin
                     nxt_read_word = 16'h0000;
                     if (rd_sel != '0 && rd_sel <= 6'(rheo_pkg::MEM_LOCS)) begin
                        nxt_read_word =
                           16'(otp_wiper_memory_ff[rd_sel - 6'h01]);
                     end
                  end
                  rheo_pkg::CMD_LAST_RD: begin
                     nxt_read_word = 16'(last_loc_ff);
                  end
                  rheo_pkg::CMD_CTRL_WR: begin
                     nxt_memory_program_enable_bit =
                        cmd.data[rheo_pkg::CTRL_MPE_BIT]; // RULE13
                     nxt_wiper_write_enable_bit =
                        cmd.data[rheo_pkg::CTRL_WWE_BIT]; // RULE12
                     nxt_tolerance_cal_bit =
                        cmd.data[rheo_pkg::CTRL_TOL_BIT]; // RULE6
                  end
                  rheo_pkg::CMD_CTRL_RD: begin
                     nxt_read_word = {12'h000, program_success_flag_ff,
                        tolerance_cal_bit_ff, wiper_write_enable_bit_ff,
                        memory_program_enable_bit_ff};
                  end
                  rheo_pkg::CMD_SHUTDOWN: begin
                     nxt_shutdown = cmd.data[0]; // RULE7
                     if (cmd.data[0] && !shutdown_ff) begin
                        ev[rheo_pkg::EV_SHDN] = 1'b1;
                     end
                  end
                  default: begin
                     // nop and unused codes change nothing
                  end
               endcase
            end
         end
      endcase
      // software writes over apb steer the control bits
      if (apb_wr && paddr == rheo_pkg::CTRL_OFS && pstrb[0] &&
          !(take_cmd && cmd.code == rheo_pkg::CMD_CTRL_WR)) begin
         nxt_memory_program_enable_bit = pwdata[rheo_pkg::CTRL_MPE_BIT];
         nxt_wiper_write_enable_bit = pwdata[rheo_pkg::CTRL_WWE_BIT];
         nxt_tolerance_cal_bit = pwdata[rheo_pkg::CTRL_TOL_BIT]; // RULE6
      end
      // reset pin held low reloads the wiper, even if writes are blocked
      if (!reset_pin_n && seq_ff != rheo_pkg::SEQ_MID) begin
         nxt_wiper_register = restore_val; // RULE4
         nxt_shutdown = 1'b0; // RULE8
         ev[rheo_pkg::EV_RELOAD] = 1'b1;
      end
   end

   // register stage of the interpreter
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         seq_ff <= rheo_pkg::SEQ_MID;
         wiper_register_ff <= '0;
         otp_wiper_memory_ff <= '{default: '0};
         last_loc_ff <= '0;
         busy_cnt_ff <= '0;
         memory_program_enable_bit_ff <= rheo_pkg::CTRL_RESET[0]; // RULE13
         wiper_write_enable_bit_ff <= rheo_pkg::CTRL_RESET[1]; // RULE12
         tolerance_cal_bit_ff <= rheo_pkg::CTRL_RESET[2]; // RULE6
         program_success_flag_ff <= 1'b0;
         shutdown_ff <= 1'b0;
         read_word_ff <= 16'h0000;
      end else begin
         seq_ff <= nxt_seq;
         wiper_register_ff <= nxt_wiper_register;
         otp_wiper_memory_ff <= nxt_otp_wiper_memory;
         last_loc_ff <= nxt_last_loc;
         busy_cnt_ff <= nxt_busy_cnt;
         memory_program_enable_bit_ff <= nxt_memory_program_enable_bit;
         wiper_write_enable_bit_ff <= nxt_wiper_write_enable_bit;
         tolerance_cal_bit_ff <= nxt_tolerance_cal_bit;
         program_success_flag_ff <= nxt_program_success_flag;
         shutdown_ff <= nxt_shutdown;
         read_word_ff <= nxt_read_word;
      end
   end

   assign read_word = read_word_ff;
   assign wiper_a_connect = !shutdown_ff; // RULE7
   assign tolerance_cal_en = tolerance_cal_bit_ff;

   // one-hot tap decode, one flip-flop per tap
   generate
      for (genvar t = 0; t < TAPS; t++) begin : g_tap
         logic tap_ff, nxt_tap;
         assign nxt_tap = (wiper_register_ff == WIPER_BITS'(t)); // RULE10
         always_ff @(posedge pclk or negedge presetn) begin
            if (!presetn) begin
               tap_ff <= 1'b0;
            end else begin
               tap_ff <= nxt_tap;
            end
         end
         assign tap_sel[t] = tap_ff;
      end
   endgenerate

   // interrupt status, mask and apb read data
   always_comb begin
      nxt_int_sts = int_sts_ff;
      nxt_int_mask = int_mask_ff;
      nxt_prdata = prdata_ff;
      if (apb_wr && paddr == rheo_pkg::INT_STS_OFS && pstrb[0]) begin
         nxt_int_sts = int_sts_ff & ~pwdata[rheo_pkg::EV_BITS-1:0];
      end
      if (apb_wr && paddr == rheo_pkg::INT_MASK_OFS && pstrb[0]) begin
         nxt_int_mask = pwdata[rheo_pkg::EV_BITS-1:0];
      end
      nxt_int_sts = nxt_int_sts | ev; // set wins over clear
      if (apb_rd) begin
         unique case (paddr)
            rheo_pkg::CTRL_OFS: nxt_prdata = {28'h0000000,
               program_success_flag_ff, tolerance_cal_bit_ff,
               wiper_write_enable_bit_ff, memory_program_enable_bit_ff};
            rheo_pkg::STATE_OFS: nxt_prdata = {6'h00, shutdown_ff,
               seq_ff == rheo_pkg::SEQ_BUSY, 2'h0, last_loc_ff,
               16'(wiper_register_ff)};
            rheo_pkg::INT_STS_OFS: nxt_prdata = 32'(int_sts_ff);
            rheo_pkg::INT_MASK_OFS: nxt_prdata = 32'(int_mask_ff);
            default: nxt_prdata = 32'h00000000;
         endcase
      end
   end

   // register stage of the interrupt and bus logic
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         int_sts_ff <= '0;
         int_mask_ff <= '0;
         prdata_ff <= 32'h00000000;
      end else begin
         int_sts_ff <= nxt_int_sts;
         int_mask_ff <= nxt_int_mask;
         prdata_ff <= nxt_prdata;
      end
   end

   assign irq = |(int_sts_ff & int_mask_ff);
endmodule

// >>> tb/rheo_monitor.sv
// rheo_monitor: concurrent checks on the wiper control ports
// assumes a bind onto rheostat_wiper_control, one clock domain
`timescale 1ns/100ps
module rheo_monitor #(
   parameter int WIPER_BITS = 10,
   parameter int WRITE_CYCLES = 8
) (
   // clock and reset
   input wire logic pclk,
   input wire logic presetn,
   // command side
   input wire logic cmd_valid,
   input wire rheo_pkg::cmd_s cmd,
   input wire logic addr_ack_en,
   input wire logic reset_pin_n,
   // analog side and interrupt
   input wire logic [(1<<WIPER_BITS)-1:0] tap_sel,
   input wire logic wiper_a_connect,
   input wire logic tolerance_cal_en,
   input wire logic irq
);
   localparam int MID = 1 << (WIPER_BITS - 1);
   logic [31:0] lo_cnt_ff;
   logic [31:0] nxt_lo_cnt;
   logic shdn_cmd;
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   // length of the current busy stretch
   always_comb begin
      nxt_lo_cnt = addr_ack_en ? 32'h0 : lo_cnt_ff + 32'h1;
   end
   always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         lo_cnt_ff <= 32'h0;
      end else begin
         lo_cnt_ff <= nxt_lo_cnt;
      end
   end
   // shutdown command that the block may take
   assign shdn_cmd = cmd_valid && addr_ack_en && reset_pin_n
      && cmd.code == rheo_pkg::CMD_SHUTDOWN;
   property p_busy_len;
      $rose(addr_ack_en) |-> lo_cnt_ff == WRITE_CYCLES;
   endproperty
   a_busy_len: assert property (p_busy_len)
      else $error("write cycle ended early");
   property p_busy_max;
      lo_cnt_ff <= WRITE_CYCLES;
   endproperty
   a_busy_max: assert property (p_busy_max)
      else $error("write cycle too long");
   property p_drop;
      !addr_ack_en && cmd_valid && reset_pin_n |=> ##1 $stable(tap_sel);
   endproperty
   a_drop: assert property (p_drop)
      else $error("command acted on while busy");
   property p_tol_def;
      $rose(presetn) |-> tolerance_cal_en;
   endproperty
   a_tol_def: assert property (p_tol_def)
      else $error("calibration off after reset");
   property p_shdn_in;
      shdn_cmd && cmd.data[0] && $past(presetn, 3) |=> !wiper_a_connect;
   endproperty
   a_shdn_in: assert property (p_shdn_in)
      else $error("shutdown not entered");
   property p_shdn_out;
      shdn_cmd && !cmd.data[0] && $past(presetn, 3) |=> wiper_a_connect;
   endproperty
   a_shdn_out: assert property (p_shdn_out)
      else $error("shutdown not left");
   property p_pin_exit;
      !reset_pin_n && $past(presetn) |=> wiper_a_connect;
   endproperty
   a_pin_exit: assert property (p_pin_exit)
      else $error("reset pin left shutdown on");
   property p_onehot;
      $past(presetn, 3) |-> $onehot(tap_sel);
   endproperty
   a_onehot: assert property (p_onehot)
      else $error("tap select not one hot");
   property p_preset;
      $rose(presetn) |-> ##2 tap_sel[MID] [*2];
   endproperty
   a_preset: assert property (p_preset)
      else $error("power-up preset not midscale");
   // main scenarios reached
   c_shdn: cover property (shdn_cmd && cmd.data[0]);
   c_busy: cover property ($fell(addr_ack_en));
   c_irq: cover property (irq);
endmodule

// >>> tb/rheo_commander.sv
// rheo_commander: serial controller model issuing decoded commands
// assumes the block's acknowledge-enable level and a shared pclk
`timescale 1ns/100ps
module rheo_commander (
   // clock
   input wire logic pclk,
   // device side
   input wire logic addr_ack_en,
   output rheo_pkg::cmd_s cmd,
   output logic cmd_valid
);
   initial begin
      cmd_valid = 1'b0;
      cmd = '0;
   end
   // poll own address until acknowledged, then send one command
   task automatic send(input logic [3:0] code, input logic [9:0] data,
         input bit poll);
      if (poll) begin
         @(negedge pclk);
         while (!addr_ack_en) begin
            @(negedge pclk);
         end
      end
      @(posedge pclk);
      cmd_valid <= 1'b1;
      cmd <= {code, data};
      @(posedge pclk);
      cmd_valid <= 1'b0;
      cmd <= ~cmd; // released bus shows the bitwise inverse of the last command
      @(posedge pclk);
   endtask
endmodule

// >>> tb/tb.sv
// tb: self-checking bench of the rheostat wiper control
// assumes the commander model and the port monitor beside the block
`timescale 1ns/100ps
module tb;
   localparam int WB = 10;
   logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
   logic pwrite = 1'b0, reset_pin_n = 1'b1, rerr;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0, prdata, rd;
   logic [3:0] pstrb = 4'hF;
   logic pready, pslverr, cmd_valid, addr_ack_en;
   logic wiper_a_connect, tolerance_cal_en, irq;
   logic [15:0] read_word;
   logic [(1<<WB)-1:0] tap_sel;
   rheo_pkg::cmd_s cmd;
   int n_mismatch = 0, num_checks = 0;
   always #4 pclk = ~pclk;
   rheostat_wiper_control #(.WIPER_BITS(WB), .WRITE_CYCLES(8)) dut_u (
      .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
      .prdata, .pready, .pslverr, .cmd_valid, .cmd, .addr_ack_en,
      .read_word, .reset_pin_n, .tap_sel, .wiper_a_connect,
      .tolerance_cal_en, .irq);
   rheo_commander cmdr_u (.pclk, .addr_ack_en, .cmd, .cmd_valid);
   // comparison and reporting
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      num_checks++;
      if (got !== exp) begin
         n_mismatch++;
         $display("[ERR] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic finish_test;
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask
   // one apb transfer, read data and error taken at the ready edge
   task automatic apb(input logic wr, input logic [7:0] a,
         input logic [31:0] d);
      @(posedge pclk);
      psel <= 1'b1;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge pclk);
      penable <= 1'b1;
      @(posedge pclk);
      while (pready !== 1'b1) @(posedge pclk);
      rd = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask
   task automatic wiper_is(input logic [9:0] w);
      apb(1'b0, rheo_pkg::STATE_OFS, 32'h0);
      check(rd & 32'h3FF, {22'h0, w});
      check({31'h0, tap_sel[w]}, 32'h1);
   endtask
   task automatic do_reset;
      presetn <= 1'b0;
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      repeat (4) @(posedge pclk);
   endtask
   task automatic t_defaults;
      apb(1'b0, rheo_pkg::CTRL_OFS, 32'h0);
      check(rd, 32'h4);
      check({31'h0, tolerance_cal_en}, 32'h1);
      wiper_is(10'h200);
      cmdr_u.send(rheo_pkg::CMD_WIPER_WR, 10'h155, 1'b1);
      wiper_is(10'h200);
      cmdr_u.send(rheo_pkg::CMD_PROGRAM, 10'h0, 1'b1);
      @(negedge pclk);
      check({31'h0, addr_ack_en}, 32'h1);
   endtask
   task automatic t_program;
      cmdr_u.send(rheo_pkg::CMD_CTRL_WR, 10'h7, 1'b1);
      cmdr_u.send(rheo_pkg::CMD_WIPER_WR, 10'h100, 1'b1);
      cmdr_u.send(rheo_pkg::CMD_PROGRAM, 10'h0, 1'b1);
      @(negedge pclk);
      check({31'h0, addr_ack_en}, 32'h0);
      apb(1'b0, rheo_pkg::STATE_OFS, 32'h0);
      check({31'h0, rd[rheo_pkg::ST_BUSY_BIT]}, 32'h1);
      check({26'h0, rd[rheo_pkg::ST_LAST_LSB +: 6]}, 32'h1);
      cmdr_u.send(rheo_pkg::CMD_WIPER_WR, 10'h3FF, 1'b0);
      cmdr_u.send(rheo_pkg::CMD_LAST_RD, 10'h0, 1'b1);
      check({16'h0, read_word}, 32'h1);
      wiper_is(10'h100);
      apb(1'b0, rheo_pkg::CTRL_OFS, 32'h0);
      check(rd, 32'hF);
      cmdr_u.send(rheo_pkg::CMD_WIPER_WR, 10'h2A5, 1'b1);
      cmdr_u.send(rheo_pkg::CMD_PROGRAM, 10'h0, 1'b1);
      cmdr_u.send(rheo_pkg::CMD_WIPER_WR, 10'h011, 1'b1);
      cmdr_u.send(rheo_pkg::CMD_LAST_RD, 10'h0, 1'b1);
      check({16'h0, read_word}, 32'h2);
      cmdr_u.send(rheo_pkg::CMD_MEM_RD, 10'h002, 1'b1);
      check({16'h0, read_word}, 32'h2A5);
      cmdr_u.send(rheo_pkg::CMD_WIPER_RD, 10'h0, 1'b1);
      check({16'h0, read_word}, 32'h011);
      cmdr_u.send(rheo_pkg::CMD_CTRL_RD, 10'h0, 1'b1);
      check({16'h0, read_word}, 32'hF);
      cmdr_u.send(rheo_pkg::CMD_SW_RESET, 10'h0, 1'b1);
      wiper_is(10'h2A5);
   endtask
   task automatic t_shutdown;
      cmdr_u.send(rheo_pkg::CMD_SHUTDOWN, 10'h1, 1'b1);
      check({31'h0, wiper_a_connect}, 32'h0);
      cmdr_u.send(rheo_pkg::CMD_WIPER_WR, 10'h055, 1'b1);
      wiper_is(10'h055);
      check({31'h0, rd[rheo_pkg::ST_SHDN_BIT]}, 32'h1);
      cmdr_u.send(rheo_pkg::CMD_SHUTDOWN, 10'h0, 1'b1);
      check({31'h0, wiper_a_connect}, 32'h1);
      cmdr_u.send(rheo_pkg::CMD_SHUTDOWN, 10'h1, 1'b1);
      reset_pin_n <= 1'b0;
      repeat (2) @(posedge pclk);
      reset_pin_n <= 1'b1;
      repeat (3) @(posedge pclk);
      check({31'h0, wiper_a_connect}, 32'h1);
      wiper_is(10'h2A5);
      cmdr_u.send(rheo_pkg::CMD_CTRL_WR, 10'h3, 1'b1);
      check({31'h0, tolerance_cal_en}, 32'h0);
      apb(1'b1, rheo_pkg::CTRL_OFS, 32'h7);
      @(negedge pclk);
      check({31'h0, tolerance_cal_en}, 32'h1);
   endtask
   task automatic t_irq;
      apb(1'b0, rheo_pkg::INT_STS_OFS, 32'h0);
      check(rd, 32'hF);
      apb(1'b1, rheo_pkg::INT_MASK_OFS, 32'hF);
      @(negedge pclk);
      check({31'h0, irq}, 32'h1);
      apb(1'b1, rheo_pkg::INT_MASK_OFS, 32'h0);
      @(negedge pclk);
      check({31'h0, irq}, 32'h0);
      apb(1'b1, rheo_pkg::INT_STS_OFS, 32'hF);
      apb(1'b0, rheo_pkg::INT_STS_OFS, 32'h0);
      check(rd, 32'h0);
      apb(1'b0, 8'h10, 32'h0);
      check({rd[30:0], rerr}, 32'h1);
   endtask
   // main sequence, second reset clears the programmed memory
   initial begin
      do_reset;
      t_defaults;
      t_program;
      t_shutdown;
      t_irq;
      do_reset;
      wiper_is(10'h200);
      finish_test;
   end
   // watchdog against a hang
   initial begin
      repeat (5000) @(posedge pclk);
      n_mismatch++;
      finish_test;
   end
endmodule
bind rheostat_wiper_control rheo_monitor #(.WIPER_BITS(WIPER_BITS),
   .WRITE_CYCLES(WRITE_CYCLES)) mon_u (.pclk, .presetn, .cmd_valid, .cmd,
   .addr_ack_en, .reset_pin_n, .tap_sel, .wiper_a_connect,
   .tolerance_cal_en, .irq);
